// File: rtl/fssp_pkg.sv
// Constants and helpers shared by the framed synchronous serial port.
// Contract
// - Transmit and receive run separately and concurrently.
// - Both holding registers support byte or word.
// - Shift registers hidden; only holding registers accessible.
// - Loopback feeds receive data/sync from transmit.
// - Loopback receive clock: transmit clock or pin.
// - Without loopback, receive signals come from pins.
// - Loopback still drives transmit pins; ignores receive data/sync pins.
// - Reset control value 0y00h, y is 10 plus clocks.
// - Copy holding to shift when empty and rewritten.
// - Rewrite before copy replaces pending holding value.
// - Internal frame sync generated, pin is output; the code pulses it only when sync mode is set.
// - No new word in time: resend previous.
// - External frame sync: pin input, partner supplies pulses.
// - Sync mode allows burst; otherwise continuous only.
// - Last write wins; external sync restarts shifter.
// - Receive starts at sync, samples falling edges MSB-first.
// - Word complete: receive event, copy to holding.
// - New receive sync mid-word restarts bit counter.
package fssp_pkg;

    // ==========================================================
    // Widths
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    localparam int ADDR_W = 8;
    localparam logic [CNT_W-1:0] LEN_BYTE = 5'h08;
    localparam logic [CNT_W-1:0] LEN_WORD = 5'h10;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

    // ==========================================================
    // Register offsets in data space
    localparam logic [ADDR_W-1:0] OFS_RX_HOLD = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TX_HOLD = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h02;

    // ==========================================================
    // Control register fields
    localparam int BIT_LOOPBACK = 1;
    localparam int BIT_WORD_LEN = 2;
    localparam int BIT_FS_MODE = 3;
    localparam int BIT_CLK_SRC = 4;
    localparam int BIT_FS_DIR = 5;
    localparam int BIT_TX_RST_N = 6;
    localparam int BIT_RX_RST_N = 7;
    localparam logic [7:0] CTRL_WR_MASK = 8'hfe;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic TX_RDY_RESET = 1'b1;
    localparam logic RX_RDY_RESET = 1'b0;

    // ==========================================================
    // Helpers
    function automatic logic [CNT_W-1:0] word_bits(input logic byte_mode);
        word_bits = byte_mode ? LEN_BYTE : LEN_WORD;
    endfunction

    // Byte mode keeps the low byte, shifted to the top for MSB-first output
    function automatic logic [WORD_W-1:0] align_tx(input logic byte_mode,
                                                   input logic [WORD_W-1:0] w);
        align_tx = byte_mode ? {w[7:0], 8'h00} : w;
    endfunction

endpackage

// File: rtl/fssp_rx.sv
// Receive shifter on the falling edges of the receive bit clock.
`timescale 1ns/1ps
module fssp_rx (
    // Clock and reset of the receive domain
    input wire logic clk,
    input wire logic rst,
    // Controls already in this domain
    input wire logic byte_mode,
    // Link, after the loopback multiplexers
    input wire logic data_in,
    input wire logic fs_in,
    // Back to the core
    output logic [fssp_pkg::WORD_W-1:0] word,
    output logic done_tgl
);
    logic [fssp_pkg::WORD_W-1:0] sh_r;
    logic [fssp_pkg::WORD_W-1:0] word_r;
    logic [fssp_pkg::CNT_W-1:0] cnt_r;
    logic done_r;
    logic last;

    assign last = !fs_in && (cnt_r == fssp_pkg::CNT_ONE);

    always_ff @(negedge clk) begin
        if (rst) begin
            sh_r <= '0;
            cnt_r <= fssp_pkg::CNT_ZERO;
        end else if (fs_in) begin
            sh_r <= '0;
            cnt_r <= fssp_pkg::word_bits(byte_mode);
        end else if (cnt_r != fssp_pkg::CNT_ZERO) begin
            sh_r <= {sh_r[fssp_pkg::WORD_W-2:0], data_in};
            cnt_r <= cnt_r - fssp_pkg::CNT_ONE;
        end
    end

    // Word is stable long before the next toggle, so the core may copy it
    always_ff @(negedge clk) begin
        if (rst) begin
            word_r <= '0;
            done_r <= 1'b0;
        end else if (last) begin
            word_r <= byte_mode ? {8'h00, sh_r[6:0], data_in}
                                : {sh_r[fssp_pkg::WORD_W-2:0], data_in};
            done_r <= ~done_r;
        end
    end

    assign word = word_r;
    assign done_tgl = done_r;
endmodule

// File: rtl/fssp_top.sv
// Framed synchronous serial port: registers, crossings and pin routing.
`timescale 1ns/1ps
module fssp_top (
    // Core clock and reset
    input wire logic clock,
    input wire logic srst,
    // Data-space register access
    input wire logic [fssp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [fssp_pkg::WORD_W-1:0] reg_wdata,
    output logic [fssp_pkg::WORD_W-1:0] reg_rdata,
    // Events to the core
    output logic tx_irq,
    output logic rx_irq,
    // Transmit pins
    input wire logic tx_bit_clock,
    output logic tx_data_pin,
    input wire logic tx_frame_sync_in,
    output logic tx_frame_sync_out,
    output logic tx_frame_sync_oe_n,
    // Receive pins
    input wire logic rx_bit_clock,
    input wire logic rx_data_pin,
    input wire logic rx_frame_sync
);
    // ==========================================================
    // Declarations
    logic [7:0] ctrl_r;
    logic [fssp_pkg::WORD_W-1:0] tx_hold_r;
    logic [fssp_pkg::WORD_W-1:0] rx_hold_r;
    logic [fssp_pkg::WORD_W-1:0] rdata_r;
    logic tx_rdy_r;
    logic rx_rdy_r;
    logic rx_full_r;
    logic load_tgl_r;
    logic tx_pend_r;
    logic tx_irq_r;
    logic rx_irq_r;
    logic taken_d_r;
    logic done_d_r;
    logic [4:0] core_s1_r;
    logic [4:0] core_s2_r;
    logic [5:0] txd_s1_r;
    logic [5:0] txd_s2_r;
    logic [2:0] rxd_s1_r;
    logic [2:0] rxd_s2_r;

    logic loop_sel;
    logic clk_src;
    logic tx_en;
    logic rx_en;
    logic wr_tx;
    logic wr_ctrl;
    logic rd_rx;
    logic tx_evt;
    logic rx_evt;
    logic tx_rst;
    logic rx_rst;
    logic rx_clk_eff;
    logic rx_data_eff;
    logic rx_fs_eff;
    logic tx_data_int;
    logic tx_fs_int;
    logic taken_tgl;
    logic done_tgl;
    logic tx_empty;
    logic [fssp_pkg::WORD_W-1:0] rx_word;
    logic [fssp_pkg::WORD_W-1:0] ctrl_view;

    assign loop_sel = ctrl_r[fssp_pkg::BIT_LOOPBACK];
    assign clk_src = ctrl_r[fssp_pkg::BIT_CLK_SRC];
    assign tx_en = ctrl_r[fssp_pkg::BIT_TX_RST_N];
    assign rx_en = ctrl_r[fssp_pkg::BIT_RX_RST_N];

    // Only the holding and control registers decode; shifters have no address
    assign wr_tx = reg_wr && (reg_addr == fssp_pkg::OFS_TX_HOLD);
    assign wr_ctrl = reg_wr && (reg_addr == fssp_pkg::OFS_CTRL);
    assign rd_rx = reg_rd && (reg_addr == fssp_pkg::OFS_RX_HOLD);

    // ==========================================================
    // Crossings into the core domain
    // Bit order: tx clock level, rx clock level, taken, done, empty
    always_ff @(posedge clock) begin
        if (srst) begin
            core_s1_r <= '0;
            core_s2_r <= '0;
        end else begin
            core_s1_r <= {tx_bit_clock, rx_bit_clock, taken_tgl, done_tgl, tx_empty};
            core_s2_r <= core_s1_r;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            taken_d_r <= 1'b0;
            done_d_r <= 1'b0;
        end else begin
            taken_d_r <= core_s2_r[2];
            done_d_r <= core_s2_r[1];
        end
    end

    // Events from a held-in-reset section are masked
    assign tx_evt = tx_en && (core_s2_r[2] != taken_d_r);
    assign rx_evt = rx_en && (core_s2_r[1] != done_d_r);

    // ==========================================================
    // Control register
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_r <= fssp_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= reg_wdata[7:0] & fssp_pkg::CTRL_WR_MASK;
        end
    end

    // Clock levels read live, so after reset bits 11:8 show 10 plus them;
    // empty reads low while transmit is held in reset, as its shifter may be unclocked
    assign ctrl_view = {2'b00, rx_full_r, tx_en && core_s2_r[0], tx_rdy_r, rx_rdy_r,
                        core_s2_r[4], core_s2_r[3], ctrl_r};

    // ==========================================================
    // Transmit holding side
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_hold_r <= '0;
        end else if (wr_tx) begin
            tx_hold_r <= reg_wdata;
        end
    end

    // One toggle per pending word; rewrites while pending only replace data
    always_ff @(posedge clock) begin
        if (srst) begin
            load_tgl_r <= 1'b0;
            tx_pend_r <= 1'b0;
        end else if (!tx_en) begin
            tx_pend_r <= 1'b0;
        end else if (wr_tx && (!tx_pend_r || tx_evt)) begin
            load_tgl_r <= ~load_tgl_r;
            tx_pend_r <= 1'b1;
        end else if (tx_evt) begin
            tx_pend_r <= 1'b0;
        end
    end

    // Set from the shifter wins over the clear by a write
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_rdy_r <= fssp_pkg::TX_RDY_RESET;
        end else if (!tx_en || tx_evt) begin
            tx_rdy_r <= 1'b1;
        end else if (wr_tx) begin
            tx_rdy_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            tx_irq_r <= 1'b0;
        end else begin
            tx_irq_r <= tx_evt;
        end
    end

    // ==========================================================
    // Receive holding side
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_hold_r <= '0;
        end else if (rx_evt) begin
            rx_hold_r <= rx_word;
        end
    end

    // A new word in the same cycle as a read keeps ready set
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_rdy_r <= fssp_pkg::RX_RDY_RESET;
            rx_full_r <= 1'b0;
        end else if (!rx_en) begin
            rx_rdy_r <= 1'b0;
            rx_full_r <= 1'b0;
        end else if (rx_evt) begin
            rx_rdy_r <= 1'b1;
            rx_full_r <= rx_full_r || (rx_rdy_r && !rd_rx);
        end else if (rd_rx) begin
            rx_rdy_r <= 1'b0;
            rx_full_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rx_irq_r <= 1'b0;
        end else begin
            rx_irq_r <= rx_evt;
        end
    end

    // ==========================================================
    // Read data, one cycle after the strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                fssp_pkg::OFS_RX_HOLD: rdata_r <= rx_hold_r;
                fssp_pkg::OFS_TX_HOLD: rdata_r <= tx_hold_r;
                fssp_pkg::OFS_CTRL: rdata_r <= ctrl_view;
                default: rdata_r <= '0;
            endcase
        end
    end

    // ==========================================================
    // Transmit domain
    // Bit order: srst, enable, byte mode, sync dir, sync mode, load toggle
    always_ff @(posedge tx_bit_clock) begin
        txd_s1_r <= {srst, tx_en, ctrl_r[fssp_pkg::BIT_WORD_LEN],
                     ctrl_r[fssp_pkg::BIT_FS_DIR], ctrl_r[fssp_pkg::BIT_FS_MODE],
                     load_tgl_r};
        txd_s2_r <= txd_s1_r;
    end

    assign tx_rst = txd_s2_r[5] || !txd_s2_r[4];

    // Holding data is stable while its toggle crosses; a write landing at the
    // very edge of the copy could tear, which ready-gated writing avoids.
    fssp_tx u_tx (
        .clk(tx_bit_clock),
        .rst(tx_rst),
        .byte_mode(txd_s2_r[3]),
        .fs_dir(txd_s2_r[2]),
        .fs_mode(txd_s2_r[1]),
        .load_tgl(txd_s2_r[0]),
        .word(tx_hold_r),
        .fs_in(tx_frame_sync_in),
        .data_out(tx_data_int),
        .fs_out(tx_fs_int),
        .taken_tgl(taken_tgl),
        .empty(tx_empty)
    );

    // Transmit pins stay driven in loopback
    assign tx_data_pin = tx_data_int;
    assign tx_frame_sync_out = tx_fs_int;
    assign tx_frame_sync_oe_n = ~ctrl_r[fssp_pkg::BIT_FS_DIR];

    // ==========================================================
    // Receive routing and domain
    // Clock mux is static in use; change the select only while receive is reset
    assign rx_clk_eff = (loop_sel && clk_src) ? tx_bit_clock : rx_bit_clock;
    // Loopback relies on the internal sync, so software sets sync dir and sync mode
    assign rx_data_eff = loop_sel ? tx_data_int : rx_data_pin;
    assign rx_fs_eff = loop_sel ? tx_fs_int : rx_frame_sync;

    always_ff @(negedge rx_clk_eff) begin
        rxd_s1_r <= {srst, rx_en, ctrl_r[fssp_pkg::BIT_WORD_LEN]};
        rxd_s2_r <= rxd_s1_r;
    end

    assign rx_rst = rxd_s2_r[2] || !rxd_s2_r[1];

    fssp_rx u_rx (
        .clk(rx_clk_eff),
        .rst(rx_rst),
        .byte_mode(rxd_s2_r[0]),
        .data_in(rx_data_eff),
        .fs_in(rx_fs_eff),
        .word(rx_word),
        .done_tgl(done_tgl)
    );

    // ==========================================================
    // Outputs
    assign reg_rdata = rdata_r;
    assign tx_irq = tx_irq_r;
    assign rx_irq = rx_irq_r;
endmodule

// File: rtl/fssp_tx.sv
// Transmit shifter on the transmit bit clock.
`timescale 1ns/1ps
module fssp_tx (
    // Clock and reset of the transmit domain
    input wire logic clk,
    input wire logic rst,
    // Controls already in this domain; word is read straight from the core holding register
    input wire logic byte_mode,
    input wire logic fs_dir,
    input wire logic fs_mode,
    input wire logic load_tgl,
    input wire logic [fssp_pkg::WORD_W-1:0] word,
    // Link
    input wire logic fs_in,
    output logic data_out,
    output logic fs_out,
    // Back to the core
    output logic taken_tgl,
    output logic empty
);
    logic [fssp_pkg::WORD_W-1:0] sh_r;
    logic [fssp_pkg::WORD_W-1:0] hold_r;
    logic [fssp_pkg::CNT_W-1:0] cnt_r;
    logic seen_r;
    logic fs_in_r;
    logic fs_out_r;
    logic taken_r;
    logic empty_r;
    logic pend;
    logic want;
    logic start;
    logic [fssp_pkg::WORD_W-1:0] src;

    assign pend = load_tgl != seen_r;
    // Burst mode only frames a word that was written; continuous always runs
    assign want = (fs_mode ? pend : 1'b1) && (cnt_r <= fssp_pkg::CNT_ONE) && !fs_out_r;
    // External sync always restarts the shifter, even mid-word
    assign start = fs_dir ? (fs_mode ? fs_out_r : want) : fs_in_r;
    assign src = pend ? word : hold_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            fs_in_r <= 1'b0;
            fs_out_r <= 1'b0;
        end else begin
            fs_in_r <= fs_in;
            fs_out_r <= fs_dir && fs_mode && want;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sh_r <= '0;
            cnt_r <= fssp_pkg::CNT_ZERO;
        end else if (start) begin
            sh_r <= fssp_pkg::align_tx(byte_mode, src);
            cnt_r <= fssp_pkg::word_bits(byte_mode);
        end else if (cnt_r != fssp_pkg::CNT_ZERO) begin
            sh_r <= {sh_r[fssp_pkg::WORD_W-2:0], 1'b0};
            cnt_r <= cnt_r - fssp_pkg::CNT_ONE;
        end
    end

    // Reset leaves a pending copy so the first frame sends what was written
    always_ff @(posedge clk) begin
        if (rst) begin
            seen_r <= ~load_tgl;
            hold_r <= '0;
            taken_r <= 1'b0;
        end else if (start && pend) begin
            seen_r <= load_tgl;
            hold_r <= word;
            taken_r <= ~taken_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            empty_r <= 1'b1;
        end else begin
            empty_r <= (cnt_r <= fssp_pkg::CNT_ONE) && !start;
        end
    end

    assign data_out = sh_r[fssp_pkg::WORD_W-1];
    assign fs_out = fs_out_r;
    assign taken_tgl = taken_r;
    assign empty = empty_r;
endmodule

// File: tb/fssp_asserts.sv
// Concurrent checks on the serial port's top-level pins.
`timescale 1ns/1ps
module fssp_asserts (
    // Core side
    input wire logic clock,
    input wire logic srst,
    input wire logic [fssp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [fssp_pkg::WORD_W-1:0] reg_wdata,
    input wire logic [fssp_pkg::WORD_W-1:0] reg_rdata,
    input wire logic tx_irq,
    input wire logic rx_irq,
    // Transmit link
    input wire logic tx_bit_clock,
    input wire logic tx_frame_sync_out,
    input wire logic tx_frame_sync_oe_n
);
    // ======================
    // Core domain
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    wire logic ctrl_wr;
    assign ctrl_wr = reg_wr && (reg_addr == fssp_pkg::OFS_CTRL);

    AST_RST_QUIET: assert property (
        $fell(srst) |-> tx_frame_sync_oe_n && !tx_irq && !rx_irq && reg_rdata == 16'h0000)
        else $error("outputs not quiet after reset");
    AST_RDATA_HOLD: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_UNMAPPED: assert property (
        reg_rd && reg_addr > fssp_pkg::OFS_CTRL |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_CTRL_RSVD: assert property (
        reg_rd && reg_addr == fssp_pkg::OFS_CTRL |=> reg_rdata[15:14] == 2'h0 && !reg_rdata[0])
        else $error("reserved control bits not zero");
    AST_OE_FOLLOWS: assert property (
        ctrl_wr |=> tx_frame_sync_oe_n == !$past(reg_wdata[fssp_pkg::BIT_FS_DIR]))
        else $error("frame sync direction not taken from write");
    AST_OE_HOLD: assert property (
        !ctrl_wr |=> $stable(tx_frame_sync_oe_n))
        else $error("frame sync direction changed without write");
    AST_TXI_PULSE: assert property (
        tx_irq |=> !tx_irq [*2])
        else $error("transmit event not a single pulse");
    AST_RXI_PULSE: assert property (
        rx_irq |=> !rx_irq [*3])
        else $error("receive event not a single pulse");

    // ======================
    // Transmit link domain
    AST_FS_ONE_BIT: assert property (
        @(posedge tx_bit_clock) disable iff (srst) tx_frame_sync_out |=> !tx_frame_sync_out)
        else $error("frame sync wider than one bit clock");
endmodule

bind fssp_top fssp_asserts fssp_asserts_i (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .tx_bit_clock(tx_bit_clock), .tx_frame_sync_out(tx_frame_sync_out),
    .tx_frame_sync_oe_n(tx_frame_sync_oe_n)
);

// File: tb/fssp_codec.sv
// Behavioural serial codec: bit clock, receive-side sender, transmit capture.
`timescale 1ns/1ps
module fssp_codec (
    // Bench controls
    input wire logic run,
    input wire logic byte_mode,
    input wire logic jam,
    // Link
    output logic bclk,
    input wire logic tx_data,
    input wire logic fs_out,
    input wire logic fs_oe_n,
    output logic fs_ext,
    output logic rx_data,
    output wire logic rx_fs,
    // Captured transmit words
    output logic [15:0] got_word,
    output logic [7:0] got_cnt
);
    logic fs_r = 1'b0;
    logic [15:0] sh = 16'h0000;
    logic [4:0] cnt = 5'h00;

    // Jam holds the receive sync pin high to prove it is ignored
    assign rx_fs = fs_r | jam;

    initial begin
        bclk = 1'b0;
        fs_ext = 1'b0;
        rx_data = 1'b0;
        got_word = 16'h0000;
        got_cnt = 8'h00;
    end

    // ======================
    // Bit clock, parked low until the bench starts it
    initial begin
        #7;
        forever begin
            #15;
            if (run) bclk = ~bclk;
        end
    end

    // ======================
    // Capture on falling edges; a new sync on the last bit still lets that word complete
    always @(negedge bclk) begin
        if (cnt != 5'h00) begin
            sh <= {sh[14:0], tx_data};
            cnt <= cnt - 5'h01;
            if (cnt == 5'h01) begin
                got_word <= {sh[14:0], tx_data};
                got_cnt <= got_cnt + 8'h01;
            end
        end
        if (fs_oe_n ? fs_ext : fs_out) begin
            cnt <= byte_mode ? 5'h08 : 5'h10;
        end
    end

    // ======================
    // Sender: k bits of an n-bit word, MSB first, then idle data flips
    task automatic send(input logic [15:0] w, input int n, input int k);
        int i;
        @(posedge bclk);
        fs_r <= 1'b1;
        for (i = n - 1; i >= n - k; i--) begin
            @(posedge bclk);
            fs_r <= 1'b0;
            rx_data <= w[i];
        end
        @(posedge bclk);
        rx_data <= ~rx_data;
    endtask

    task automatic frame;
        @(negedge bclk);
        fs_ext <= 1'b1;
        @(negedge bclk);
        fs_ext <= 1'b0;
    endtask
endmodule

// File: tb/tb_framed_sync_serial_port.sv
// Self-checking bench for the framed synchronous serial port.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end
module tb_framed_sync_serial_port;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [fssp_pkg::ADDR_W-1:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [fssp_pkg::WORD_W-1:0] reg_wdata = 16'h0000;
    logic [fssp_pkg::WORD_W-1:0] reg_rdata, rv, got_word;
    logic tx_irq, rx_irq, bclk, tx_data, fs_ext, fs_out, fs_oe_n, rx_data, rx_fs;
    logic run = 1'b0;
    logic bmode = 1'b0;
    logic jam = 1'b0;
    logic [7:0] got_cnt;
    int ev[3] = '{0, 0, 0};
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;

    always #5 clock = ~clock;

    fssp_top fssp_top_i (
        .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_irq(tx_irq), .rx_irq(rx_irq),
        .tx_bit_clock(bclk), .tx_data_pin(tx_data), .tx_frame_sync_in(fs_ext),
        .tx_frame_sync_out(fs_out), .tx_frame_sync_oe_n(fs_oe_n), .rx_bit_clock(bclk),
        .rx_data_pin(rx_data), .rx_frame_sync(rx_fs)
    );
    fssp_codec fssp_codec_i (
        .run(run), .byte_mode(bmode), .jam(jam), .bclk(bclk), .tx_data(tx_data),
        .fs_out(fs_out), .fs_oe_n(fs_oe_n), .fs_ext(fs_ext), .rx_data(rx_data),
        .rx_fs(rx_fs), .got_word(got_word), .got_cnt(got_cnt)
    );

    // ======================
    // Event counters and hang guard
    always @(posedge clock) begin
        cyc++;
        if (rx_irq === 1'b1) ev[0]++;
        if (tx_irq === 1'b1) ev[1]++;
        ev[2] = int'(got_cnt);
        if (cyc == 20000) begin
            fail_count++;
            wrap_up;
        end
    end

    // ======================
    // Access tasks
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        rv = reg_rdata;
    endtask

    // Leaves time for the control bits to reach both link domains
    task cfg(input logic [15:0] d);
        wr(fssp_pkg::OFS_CTRL, d);
        repeat (10) @(posedge clock);
    endtask

    task wait_ev(input int k, input int n);
        repeat (800) if (ev[k] < n) @(posedge clock);
    endtask

    task done(input string s);
        $display("test %s finished", s);
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ======================
    // Test sequence
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rd(fssp_pkg::OFS_CTRL);
        `CHK("ctrl reset", 16'h0800, rv)
        `CHK("fs oe_n reset", 1'b1, fs_oe_n)
        done("reset");
        run <= 1'b1;
        wr(8'h7f, 16'hffff);
        rd(8'h7f);
        `CHK("unmapped", 16'h0000, rv)
        cfg(16'hff3f);
        rd(fssp_pkg::OFS_CTRL);
        `CHK("ctrl bits", 16'h003e, rv & 16'hc0ff)
        `CHK("fs oe_n out", 1'b0, fs_oe_n)
        done("registers");
        wr(fssp_pkg::OFS_TX_HOLD, 16'ha53c);
        cfg(16'h00e8);
        wait_ev(2, 1);
        `CHK("tx word", 16'ha53c, got_word)
        `CHK("tx events", 1, ev[1])
        bmode <= 1'b1;
        cfg(16'h00ec);
        wr(fssp_pkg::OFS_TX_HOLD, 16'h1281);
        wait_ev(2, 2);
        `CHK("tx byte", 8'h81, got_word[7:0])
        done("transmit");
        bmode <= 1'b0;
        cfg(16'h00e8);
        wr(fssp_pkg::OFS_TX_HOLD, 16'h1111);
        wait_ev(1, 3);
        wr(fssp_pkg::OFS_TX_HOLD, 16'h2222);
        wr(fssp_pkg::OFS_TX_HOLD, 16'h3333);
        wait_ev(2, 3);
        `CHK("burst first", 16'h1111, got_word)
        wait_ev(2, 4);
        `CHK("last write", 16'h3333, got_word)
        `CHK("transfers", 4, ev[1])
        done("overwrite");
        cfg(16'h00c8);
        `CHK("fs oe_n in", 1'b1, fs_oe_n)
        fssp_codec_i.frame();
        wait_ev(2, 5);
        `CHK("resend", 16'h3333, got_word)
        `CHK("no transfer", 4, ev[1])
        done("external sync");
        fssp_codec_i.send(16'hc35a, 16, 16);
        wait_ev(0, 1);
        rd(fssp_pkg::OFS_CTRL);
        `CHK("rx ready set", 1'b1, rv[10])
        `CHK("tx empty", 1'b1, rv[12])
        rd(fssp_pkg::OFS_RX_HOLD);
        `CHK("rx word", 16'hc35a, rv)
        rd(fssp_pkg::OFS_CTRL);
        `CHK("rx ready clear", 1'b0, rv[10])
        fssp_codec_i.send(16'hffff, 16, 5);
        fssp_codec_i.send(16'h0a5c, 16, 16);
        wait_ev(0, 2);
        rd(fssp_pkg::OFS_RX_HOLD);
        `CHK("restart", 16'h0a5c, rv)
        `CHK("rx events", 2, ev[0])
        bmode <= 1'b1;
        cfg(16'h00cc);
        fssp_codec_i.send(16'h0062, 8, 8);
        wait_ev(0, 3);
        rd(fssp_pkg::OFS_RX_HOLD);
        `CHK("rx byte", 16'h0062, rv)
        fssp_codec_i.send(16'h00a7, 8, 8);
        fssp_codec_i.send(16'h00b5, 8, 8);
        wait_ev(0, 5);
        rd(fssp_pkg::OFS_CTRL);
        `CHK("rx overrun", 1'b1, rv[13])
        rd(fssp_pkg::OFS_RX_HOLD);
        `CHK("rx newest", 16'h00b5, rv)
        done("receive");
        bmode <= 1'b0;
        cfg(16'h00fa);
        jam <= 1'b1;
        wr(fssp_pkg::OFS_TX_HOLD, 16'h6e91);
        rd(fssp_pkg::OFS_CTRL);
        `CHK("tx ready clear", 1'b0, rv[11])
        wait_ev(0, 6);
        rd(fssp_pkg::OFS_RX_HOLD);
        `CHK("loopback rx", 16'h6e91, rv)
        wait_ev(2, 6);
        `CHK("loopback pin", 16'h6e91, got_word)
        rd(fssp_pkg::OFS_CTRL);
        `CHK("tx ready set", 1'b1, rv[11])
        jam <= 1'b0;
        done("loopback");
        wrap_up;
    end
endmodule
